// [verilog/hmfis_pkg.sv]
// Constants for the host MAC and FIFO interrupt status block
package hmfis_pkg;

  // Register byte offsets on the host register port
  localparam logic [7:0] STATUS_OFFSET = 8'h50;
  localparam logic [7:0] ENABLE_OFFSET = 8'h5C;
  localparam logic [7:0] LEVEL_OFFSET = 8'h68;

  // Status bit positions
  localparam int OVERSIZE_BIT = 15;
  localparam int RX_FAULT_BIT = 14;
  localparam int TX_FAULT_BIT = 13;
  localparam int PIN_EVENT_BIT = 12;
  localparam int TX_OVERRUN_BIT = 10;
  localparam int TX_SPACE_BIT = 9;
  localparam int TX_REP_FULL_BIT = 8;
  localparam int TX_REP_LEVEL_BIT = 7;
  localparam int RX_DROP_BIT = 6;
  localparam int RX_REP_FULL_BIT = 4;
  localparam int RX_REP_LEVEL_BIT = 3;

  // Write-one-clear flags, writable enables
  localparam logic [15:0] W1C_MASK = 16'hE7D8;
  localparam logic [15:0] ENABLE_WMASK = 16'hFFF8;

  // Level register field positions
  localparam int TX_SPACE_LVL_LSB = 24;
  localparam int TX_REP_LVL_LSB = 16;
  localparam int RX_REP_LVL_LSB = 0;

  // Reset values
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [7:0] TX_SPACE_LVL_RESET = 8'h48;
  localparam logic [7:0] TX_REP_LVL_RESET = 8'h00;
  localparam logic [7:0] RX_REP_LVL_RESET = 8'h00;

  // Frame length limits in bytes
  localparam logic [13:0] OVERSIZE_LIMIT = 14'h0800;
  localparam logic [13:0] TAGGED_LIMIT = 14'h07FC;

endpackage : hmfis_pkg

// [verilog/hmfis_flag.sv]
// One sticky write-one-clear status flag
`timescale 1ns/10ps
module hmfis_flag (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Event and clear
  input wire logic set,
  input wire logic clr,
  // Flag state
  output logic flag
);

  typedef struct packed {
    logic flag;
  } hmfis_flag_state_t;

  hmfis_flag_state_t state_ff;
  hmfis_flag_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    // Set wins over a clear in the same cycle
    if (set) begin
      nxt_state.flag = 1'b1;
    end else if (clr) begin
      nxt_state.flag = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign flag = state_ff.flag;

endmodule : hmfis_flag

// [verilog/hmfis_status.sv]
// Host MAC and FIFO interrupt status, enable and level registers
`timescale 1ns/10ps
// Function
// - Receiver fault sets bit 14; sticky until one written; resets zero.
// - Transmitter fault sets bit 13; cleared by writing one; resets zero.
// - Bit 12 read-only, follows pending pin-block interrupt.
// - Write to full transmit payload FIFO sets bit 10; write one clears.
// - Free transmit space rising above its level sets bit 9; write one clears.
// - Transmit report queue becoming full sets bit 8; write one clears.
// - Transmit report queue passing its level sets bit 7; write one clears.
// - Each dropped received frame sets bit 6; write one clears.
// - Receive report queue becoming full sets bit 4; write one clears.
// - Receive report queue passing its level sets bit 3; write one clears.
// - Tag inserted into untagged frame above 2044 bytes also sets bit 15.
// - Received frame longer than 2048 bytes sets bit 15; write one clears.
// - Interrupt only from enabled flags; flags record events regardless.
// - Space level 8 bits in 64-byte blocks, reset 48h; others zero.
module hmfis_status
  import hmfis_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Host register port
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  // Host MAC events
  input wire logic rx_fault_evt,
  input wire logic tx_fault_evt,
  input wire logic rx_frame_drop_evt,
  input wire logic rx_frame_done,
  input wire logic [13:0] rx_frame_len,
  input wire logic rx_tag_inserted,
  // Pin block summary
  input wire logic pin_event_pending,
  // Transmit payload FIFO
  input wire logic tx_payload_wr,
  input wire logic tx_payload_full,
  input wire logic [7:0] tx_payload_free_blocks,
  // Report queues
  input wire logic tx_report_full,
  input wire logic [7:0] tx_report_used,
  input wire logic rx_report_full,
  input wire logic [7:0] rx_report_used,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic [15:0] enable;
    logic [7:0] tx_space_lvl;
    logic [7:0] tx_rep_lvl;
    logic [7:0] rx_rep_lvl;
    logic pin_event;
    logic tx_rep_full_d;
    logic rx_rep_full_d;
    logic tx_space_d;
    logic tx_rep_lvl_d;
    logic rx_rep_lvl_d;
    logic irq;
    logic [31:0] rdata;
  } hmfis_state_t;

  hmfis_state_t state_ff;
  hmfis_state_t nxt_state;

  logic [15:0] flags;
  logic [15:0] set_evt;
  logic [15:0] clr_req;
  logic tx_space_hit;
  logic tx_rep_hit;
  logic rx_rep_hit;
  logic oversize_hit;
  logic [15:0] armed_flags;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] o);
    addr_hit = (a == o);
  endfunction : addr_hit

  assign tx_space_hit = tx_payload_free_blocks > state_ff.tx_space_lvl;
  assign tx_rep_hit = tx_report_used > state_ff.tx_rep_lvl;
  assign rx_rep_hit = rx_report_used > state_ff.rx_rep_lvl;
  assign oversize_hit = rx_frame_done &&
    ((rx_frame_len > OVERSIZE_LIMIT) ||
     (rx_tag_inserted && (rx_frame_len > TAGGED_LIMIT)));

  assign armed_flags = flags & state_ff.enable;

  always_comb begin
    set_evt = 16'h0000;
    set_evt[OVERSIZE_BIT] = oversize_hit;
    set_evt[RX_FAULT_BIT] = rx_fault_evt;
    set_evt[TX_FAULT_BIT] = tx_fault_evt;
    set_evt[TX_OVERRUN_BIT] = tx_payload_wr && tx_payload_full;
    set_evt[TX_SPACE_BIT] = tx_space_hit && !state_ff.tx_space_d;
    set_evt[TX_REP_FULL_BIT] = tx_report_full && !state_ff.tx_rep_full_d;
    set_evt[TX_REP_LEVEL_BIT] = tx_rep_hit && !state_ff.tx_rep_lvl_d;
    set_evt[RX_DROP_BIT] = rx_frame_drop_evt;
    set_evt[RX_REP_FULL_BIT] = rx_report_full && !state_ff.rx_rep_full_d;
    set_evt[RX_REP_LEVEL_BIT] = rx_rep_hit && !state_ff.rx_rep_lvl_d;
  end

  // Only ones written to the status word clear
  assign clr_req = (host_wr && addr_hit(host_addr, STATUS_OFFSET)) ?
    (host_wdata[15:0] & W1C_MASK) : 16'h0000;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_flag
      if (W1C_MASK[gi]) begin : g_sticky
        hmfis_flag u_flag (
          .clock(clock),
          .arst_n(arst_n),
          .set(set_evt[gi]),
          .clr(clr_req[gi]),
          .flag(flags[gi])
        );
      end else if (gi == PIN_EVENT_BIT) begin : g_pin
        assign flags[gi] = state_ff.pin_event;
      end else begin : g_rsvd
        assign flags[gi] = 1'b0;
      end
    end
  endgenerate

  always_comb begin
    nxt_state = state_ff;
    nxt_state.pin_event = pin_event_pending;
    nxt_state.tx_rep_full_d = tx_report_full;
    nxt_state.rx_rep_full_d = rx_report_full;
    nxt_state.tx_space_d = tx_space_hit;
    nxt_state.tx_rep_lvl_d = tx_rep_hit;
    nxt_state.rx_rep_lvl_d = rx_rep_hit;
    if (host_wr && addr_hit(host_addr, ENABLE_OFFSET)) begin
      nxt_state.enable = host_wdata[15:0] & ENABLE_WMASK;
    end
    if (host_wr && addr_hit(host_addr, LEVEL_OFFSET)) begin
      nxt_state.tx_space_lvl = host_wdata[TX_SPACE_LVL_LSB +: 8];
      nxt_state.tx_rep_lvl = host_wdata[TX_REP_LVL_LSB +: 8];
      nxt_state.rx_rep_lvl = host_wdata[RX_REP_LVL_LSB +: 8];
    end
    nxt_state.irq = |armed_flags;
    nxt_state.rdata = 32'h0000_0000;
    if (addr_hit(host_addr, STATUS_OFFSET)) begin
      nxt_state.rdata[15:0] = flags;
    end else if (addr_hit(host_addr, ENABLE_OFFSET)) begin
      nxt_state.rdata[15:0] = state_ff.enable;
    end else if (addr_hit(host_addr, LEVEL_OFFSET)) begin
      nxt_state.rdata[TX_SPACE_LVL_LSB +: 8] = state_ff.tx_space_lvl;
      nxt_state.rdata[TX_REP_LVL_LSB +: 8] = state_ff.tx_rep_lvl;
      nxt_state.rdata[RX_REP_LVL_LSB +: 8] = state_ff.rx_rep_lvl;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= '0;
      state_ff.enable <= ENABLE_RESET;
      state_ff.tx_space_lvl <= TX_SPACE_LVL_RESET;
      state_ff.tx_rep_lvl <= TX_REP_LVL_RESET;
      state_ff.rx_rep_lvl <= RX_REP_LVL_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign host_rdata = state_ff.rdata;
  assign irq = state_ff.irq;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  a_rx_fault_set: assert property (
    rx_fault_evt
    |=> flags[RX_FAULT_BIT]
  ) else begin
    $error("receiver fault flag not set");
  end

  a_rx_fault_clear: assert property (
    clr_req[RX_FAULT_BIT] && !rx_fault_evt
    |=> !flags[RX_FAULT_BIT]
  ) else begin
    $error("receiver fault flag not cleared by one");
  end

  a_tx_fault_set: assert property (
    tx_fault_evt
    |=> flags[TX_FAULT_BIT]
  ) else begin
    $error("transmitter fault flag not set");
  end

  a_tx_fault_clear: assert property (
    clr_req[TX_FAULT_BIT] && !tx_fault_evt
    |=> !flags[TX_FAULT_BIT]
  ) else begin
    $error("transmitter fault flag not cleared by one");
  end

  a_pin_follows: assert property (
    ##1 flags[PIN_EVENT_BIT]
    == $past(pin_event_pending)
  ) else begin
    $error("pin summary does not follow its source");
  end

  a_overrun_set: assert property (
    tx_payload_wr && tx_payload_full
    |=> flags[TX_OVERRUN_BIT]
  ) else begin
    $error("payload overrun flag not set");
  end

  a_space_set: assert property (
    tx_space_hit && !state_ff.tx_space_d
    |=> flags[TX_SPACE_BIT]
  ) else begin
    $error("payload space flag not set");
  end

  a_full_edge: assert property (
    tx_report_full && !state_ff.tx_rep_full_d
    |=> flags[TX_REP_FULL_BIT]
  ) else begin
    $error("transmit report full flag not set");
  end

  a_tx_level_set: assert property (
    tx_rep_hit && !state_ff.tx_rep_lvl_d
    |=> flags[TX_REP_LEVEL_BIT]
  ) else begin
    $error("transmit report level flag not set");
  end

  a_drop_set: assert property (
    rx_frame_drop_evt
    |=> flags[RX_DROP_BIT]
  ) else begin
    $error("drop flag not set");
  end

  a_drop_clear: assert property (
    clr_req[RX_DROP_BIT] && !rx_frame_drop_evt
    |=> !flags[RX_DROP_BIT]
  ) else begin
    $error("drop flag not cleared by one");
  end

  a_rx_full_edge: assert property (
    rx_report_full && !state_ff.rx_rep_full_d
    |=> flags[RX_REP_FULL_BIT]
  ) else begin
    $error("receive report full flag not set");
  end

  a_rx_level_set: assert property (
    rx_rep_hit && !state_ff.rx_rep_lvl_d
    |=> flags[RX_REP_LEVEL_BIT]
  ) else begin
    $error("receive report level flag not set");
  end

  a_tagged_set: assert property (
    rx_frame_done && rx_tag_inserted && rx_frame_len > TAGGED_LIMIT
    |=> flags[OVERSIZE_BIT]
  ) else begin
    $error("tagged oversize flag not set");
  end

  a_oversize_set: assert property (
    rx_frame_done && rx_frame_len > OVERSIZE_LIMIT
    |=> flags[OVERSIZE_BIT]
  ) else begin
    $error("oversize flag not set");
  end

  a_irq_gated: assert property (
    armed_flags != 16'h0000
    |=> irq
  ) else begin
    $error("interrupt missing for an enabled flag");
  end

  a_irq_quiet: assert property (
    armed_flags == 16'h0000
    |=> !irq
  ) else begin
    $error("interrupt raised with no enabled flag");
  end

  a_lvl_stable: assert property (
    !(host_wr && host_addr == LEVEL_OFFSET)
    |=> $stable(state_ff.tx_space_lvl) && $stable(state_ff.tx_rep_lvl) &&
    $stable(state_ff.rx_rep_lvl)
  ) else begin
    $error("level fields changed without a write");
  end

  a_rsvd_zero: assert property (
    host_addr == STATUS_OFFSET
    |=> host_rdata[31:16] == 16'h0000 && host_rdata[11] == 1'b0 &&
    host_rdata[5] == 1'b0 && host_rdata[2:0] == 3'b000
  ) else begin
    $error("reserved status bit not zero");
  end

  a_zero_keeps: assert property (
    flags[TX_SPACE_BIT] && !clr_req[TX_SPACE_BIT]
    |=> flags[TX_SPACE_BIT]
  ) else begin
    $error("flag lost without a clear");
  end

endmodule : hmfis_status

// [verification/hmfis_status_tb.sv]
// Self-checking testbench for the host MAC and FIFO interrupt status block
`timescale 1ns/10ps
module hmfis_status_tb;
  import hmfis_pkg::*;
  logic clock = 1'h0;
  logic arst_n = 1'h0;
  logic [7:0] host_addr = 8'h00;
  logic host_wr = 1'h0;
  logic [31:0] host_wdata = 32'h0;
  logic [31:0] host_rdata;
  logic rx_f = 1'h0, tx_f = 1'h0, drop = 1'h0, done = 1'h0, tag = 1'h0;
  logic pin = 1'h0, pwr = 1'h0, pfull = 1'h0, tfull = 1'h0, rfull = 1'h0;
  logic [13:0] flen = 14'h0;
  logic [7:0] free = 8'h00, tused = 8'h00, rused = 8'h00;
  logic irq;
  int num_errors = 0;
  int compares = 0;

  hmfis_status hmfis_status_i (
    .clock(clock), .arst_n(arst_n), .host_addr(host_addr),
    .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .rx_fault_evt(rx_f), .tx_fault_evt(tx_f), .rx_frame_drop_evt(drop),
    .rx_frame_done(done), .rx_frame_len(flen), .rx_tag_inserted(tag),
    .pin_event_pending(pin), .tx_payload_wr(pwr), .tx_payload_full(pfull),
    .tx_payload_free_blocks(free), .tx_report_full(tfull),
    .tx_report_used(tused), .rx_report_full(rfull),
    .rx_report_used(rused), .irq(irq)
  );

  initial begin
    forever #20 clock = ~clock;
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_addr = a;
    host_wr = 1'h1;
    host_wdata = d;
    tick();
    host_wr = 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string n);
    host_addr = a;
    tick();
    chk(n, e, host_rdata);
  endtask : rd

  // One-cycle cause for the flag at position b
  task automatic fire(input int b);
    case (b)
      14: rx_f = 1'h1;
      13: tx_f = 1'h1;
      10: {pfull, pwr} = 2'h3;
      9: free = 8'h49;
      8: tfull = 1'h1;
      7: tused = 8'h01;
      6: drop = 1'h1;
      4: rfull = 1'h1;
      3: rused = 8'h01;
      default: {done, flen} = {1'h1, 14'h0801};
    endcase
    tick();
    {rx_f, tx_f, pfull, pwr, tfull, drop, rfull, done, tag} = 9'h0;
    {free, tused, rused, flen} = 38'h0;
  endtask : fire

  task automatic t_reset;
    chk("irq", 32'h0, {31'h0, irq});
    rd(STATUS_OFFSET, 32'h0, "status");
    rd(ENABLE_OFFSET, 32'h0, "enable");
    rd(LEVEL_OFFSET, 32'h48000000, "level");
    rd(8'h54, 32'h0, "unmapped");
  endtask : t_reset

  task automatic t_events;
    int bits[10] = '{15, 14, 13, 10, 9, 8, 7, 6, 4, 3};
    foreach (bits[i]) begin
      fire(bits[i]);
      rd(STATUS_OFFSET, 32'h1 << bits[i], "set");
      wr(STATUS_OFFSET, ~(32'h1 << bits[i]));
      rd(STATUS_OFFSET, 32'h1 << bits[i], "kept");
      wr(STATUS_OFFSET, 32'h1 << bits[i]);
      rd(STATUS_OFFSET, 32'h0, "cleared");
    end
  endtask : t_events

  task automatic t_edge;
    {done, flen, free, tused} = {1'h1, 14'h0800, 8'h48, 8'h00};
    tick();
    {tag, flen, free} = {1'h1, 14'h07FC, 8'h00};
    tick();
    {done, tag, flen} = 16'h0;
    rd(STATUS_OFFSET, 32'h0, "limits");
    {done, tag, flen} = {2'h3, 14'h07FD};
    tick();
    {done, tag, flen} = 16'h0;
    rd(STATUS_OFFSET, 32'h8000, "tagged");
    wr(STATUS_OFFSET, 32'h8000);
  endtask : t_edge

  task automatic t_pin;
    pin = 1'h1;
    tick();
    rd(STATUS_OFFSET, 32'h1000, "pin");
    wr(STATUS_OFFSET, 32'h1000);
    rd(STATUS_OFFSET, 32'h1000, "pin ro");
    pin = 1'h0;
    tick();
    rd(STATUS_OFFSET, 32'h0, "pin off");
  endtask : t_pin

  task automatic t_irq;
    wr(ENABLE_OFFSET, 32'h4000);
    fire(13);
    tick();
    chk("irq masked", 32'h0, {31'h0, irq});
    fire(14);
    tick();
    chk("irq on", 32'h1, {31'h0, irq});
    wr(ENABLE_OFFSET, 32'h0);
    tick();
    chk("irq off", 32'h0, {31'h0, irq});
    rd(STATUS_OFFSET, 32'h6000, "recorded");
    wr(STATUS_OFFSET, 32'h6000);
  endtask : t_irq

  task automatic t_regs;
    tick();
    wr(ENABLE_OFFSET, 32'hFFFFFFFF);
    rd(ENABLE_OFFSET, 32'h0000FFF8, "enable w");
    chk("irq idle", 32'h0, {31'h0, irq});
    wr(LEVEL_OFFSET, 32'h12340056);
    rd(LEVEL_OFFSET, 32'h12340056, "level w");
    wr(STATUS_OFFSET, 32'hFFFFFFFF);
    rd(STATUS_OFFSET, 32'h0, "reserved");
  endtask : t_regs

  task automatic t_levels;
    {free, tused, rused} = {8'h12, 8'h34, 8'h56};
    tick();
    rd(STATUS_OFFSET, 32'h0, "at level");
    {free, tused, rused} = {8'h13, 8'h35, 8'h57};
    rx_f = 1'h1;
    wr(STATUS_OFFSET, 32'h4000);
    {free, tused, rused, rx_f} = 25'h0;
    rd(STATUS_OFFSET, 32'h4288, "set wins");
    chk("irq level", 32'h1, {31'h0, irq});
    wr(STATUS_OFFSET, 32'h4288);
  endtask : t_levels

  task automatic summarize;
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (10) @(posedge clock);
    #1;
    arst_n = 1'h1;
    t_reset();
    t_events();
    t_edge();
    t_pin();
    t_irq();
    t_regs();
    t_levels();
    summarize();
  end
endmodule : hmfis_status_tb
